// >>> logic/uart_cfg_defines.svh
// register offsets, field positions and reset values of the channel configuration block
`ifndef UART_CFG_DEFINES_SVH
`define UART_CFG_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_IRQ_SOURCE 8'h00
`define OFS_FIFO_CTRL 8'h04
`define OFS_LINE_FMT 8'h08
`define OFS_MODEM_CTRL 8'h0c
`define OFS_FEATURE 8'h10
`define OFS_RX_TRIG 8'h14
`define OFS_TX_TRIG 8'h18
`define OFS_ENH_FEATURE 8'h1c
`define OFS_LEVELS 8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FIFO_EN_BIT 0
`define RX_FLUSH_BIT 1
`define TX_FLUSH_BIT 2
`define XFER_MODE_BIT 3
`define FMT_STOP 2
`define FMT_PAR_EN 3
`define FMT_PAR_TYPE 4
`define FMT_PAR_FORCE 5
`define FMT_BREAK 6
`define FMT_DIV_SEL 7
`define MODEM_DTR 0
`define MODEM_RTS 1
`define MODEM_PAIR_SEL 2
`define MODEM_LOOP 4
`define MODEM_XON_ANY 5
`define MODEM_IR_EN 6
`define MODEM_PRESCALE 7
`define ENH_AUTO_RTS 6
`define ENH_AUTO_CTS 7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_FIFO_CTRL 8'h00
`define RST_LINE_FMT 8'h00
`define RST_MODEM_CTRL 8'h00
`define RST_FEATURE 8'h00
`define RST_TRIG 8'h01
`define RST_ENH_FEATURE 8'h00
`define IR_CAPTURE_CYCLES 2'h3

`endif

// >>> logic/uart_cfg_pkg.sv
// types shared by the channel configuration block
package uart_cfg_pkg;
  typedef enum logic [1:0] {
    table_a,
    table_b,
    table_c,
    table_d
  } trig_table_e;
endpackage

// >>> logic/uart_fifo_line_modem_control.sv
// per-channel fifo, line format and modem control logic with a wishbone register port
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "uart_cfg_defines.svh"

// Operation
// - status top bits mirror fifo enable
// - fifo control fields need enable set
// - rx flush clears rx counters, self clears
// - tx flush clears tx counters, self clears
// - transfer mode bit stored, no effect
// - tx request below trigger or empty
// - rx request when level crosses trigger
// - one shared table, table d programmable
// - table a: rx 1/4/8/14, tx 1
// - table b levels 8/16/24/28, 16/8/24/30
// - table c levels 8/16/56/60, 8/16/32/56
// - two low bits set 5..8 bit chars
// - stop bit one, 1.5 or two
// - parity enable adds and checks parity
// - parity type odd or even
// - forced parity mark or space
// - break holds transmit output low
// - top bit selects divisor latches
// - dtr and rts pins inverted
// - pair select chooses rts/cts or dtr/dsr
// - xon any resumes on any character
// - infrared enable sampled from pin after reset release
// - prescaler divides baud clock by four
// - rx request clears below trigger
// - auto cts high stops transmitter
module uart_fifo_line_modem_control
  import uart_cfg_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int CNT_W = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_push_i,
  input wire logic rx_pop_i,
  input wire logic tx_push_i,
  input wire logic tx_pop_i,
  input wire logic tx_serial_i,
  input wire logic tx_ir_i,
  input wire logic rx_flow_stop_i,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic infrared_select_pin_i,
  output logic rx_flush_o,
  output logic tx_flush_o,
  output logic rx_irq_o,
  output logic tx_irq_o,
  output logic [3:0] char_bits_o,
  output logic stop_half_o,
  output logic stop_two_o,
  output logic parity_en_o,
  output logic parity_even_o,
  output logic parity_forced_o,
  output logic parity_value_o,
  output logic divisor_sel_o,
  output logic tx_pin_o,
  output logic dtr_n_o,
  output logic rts_n_o,
  output logic tx_hold_o,
  output logic loopback_o,
  output logic xon_any_o,
  output logic ir_enable_o,
  output logic prescale_div4_o
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic fifo_en;
  logic [7:0] fifo_ctrl;
  logic [7:0] line_format_control;
  logic [7:0] modem_line_control;
  logic [7:0] feature_control;
  logic [7:0] receive_trigger_value;
  logic [7:0] transmit_trigger_value;
  logic [7:0] enhanced_feature_control;
  logic [CNT_W-1:0] rx_cnt;
  logic [CNT_W-1:0] tx_cnt;
  logic tx_filled_over;
  logic [1:0] cts_sync;
  logic [1:0] dsr_sync;
  logic [1:0] ir_sync;
  logic [1:0] ir_capture;
  logic [7:0] rx_trig;
  logic [7:0] tx_trig;
  logic wr_req;
  logic rd_req;
  logic fifo_ctl_write;
  logic [7:0] wdat;
  trig_table_e table_sel;

  assign wr_req = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  assign wdat = wb_dat_i[7:0];
  assign fifo_ctl_write = wr_req && wb_adr_i == `OFS_FIFO_CTRL;
  assign table_sel = trig_table_e'(feature_control[7:6]);

  // ----------------------------------------------------------------
  // trigger table decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] rx_level(input trig_table_e t, input logic [1:0] f, input logic [7:0] prog);
    logic [7:0] v;
    v = prog;
    case (t)
      table_a: v = (f == 2'h0) ? 8'h01 : (f == 2'h1) ? 8'h04 : (f == 2'h2) ? 8'h08 : 8'h0e;
      table_b: v = (f == 2'h0) ? 8'h08 : (f == 2'h1) ? 8'h10 : (f == 2'h2) ? 8'h18 : 8'h1c;
      table_c: v = (f == 2'h0) ? 8'h08 : (f == 2'h1) ? 8'h10 : (f == 2'h2) ? 8'h38 : 8'h3c;
      default: v = prog;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] tx_level(input trig_table_e t, input logic [1:0] f, input logic [7:0] prog);
    logic [7:0] v;
    v = prog;
    case (t)
      table_a: v = 8'h01;
      table_b: v = (f == 2'h0) ? 8'h10 : (f == 2'h1) ? 8'h08 : (f == 2'h2) ? 8'h18 : 8'h1e;
      table_c: v = (f == 2'h0) ? 8'h08 : (f == 2'h1) ? 8'h10 : (f == 2'h2) ? 8'h20 : 8'h38;
      default: v = prog;
    endcase
    return v;
  endfunction

  // one table drives both directions, so the last table choice rules both
  assign rx_trig = rx_level(table_sel, fifo_ctrl[7:6], receive_trigger_value);
  assign tx_trig = tx_level(table_sel, fifo_ctrl[5:4], transmit_trigger_value);

  // ----------------------------------------------------------------
  // fifo control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_en <= 1'b0;
      fifo_ctrl <= `RST_FIFO_CTRL;
      rx_flush_o <= 1'b0;
      tx_flush_o <= 1'b0;
    end else begin
      rx_flush_o <= 1'b0;
      tx_flush_o <= 1'b0;
      if (fifo_ctl_write) begin
        fifo_en <= wdat[`FIFO_EN_BIT];
        if (wdat[`FIFO_EN_BIT]) begin
          // transfer mode bit is stored for legacy software, it steers nothing
          fifo_ctrl <= {wdat[7:3], 3'h0};
          rx_flush_o <= wdat[`RX_FLUSH_BIT];
          tx_flush_o <= wdat[`TX_FLUSH_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // other software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_format_control <= `RST_LINE_FMT;
      feature_control <= `RST_FEATURE;
      receive_trigger_value <= `RST_TRIG;
      transmit_trigger_value <= `RST_TRIG;
      enhanced_feature_control <= `RST_ENH_FEATURE;
    end else if (wr_req) begin
      case (wb_adr_i)
        `OFS_LINE_FMT: line_format_control <= wdat;
        `OFS_FEATURE: feature_control <= wdat;
        `OFS_RX_TRIG: receive_trigger_value <= wdat;
        `OFS_TX_TRIG: transmit_trigger_value <= wdat;
        `OFS_ENH_FEATURE: enhanced_feature_control <= wdat;
        default: ;
      endcase
    end
  end

  // modem control, with the infrared bit caught from the pin after reset release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      modem_line_control <= `RST_MODEM_CTRL;
      ir_capture <= `IR_CAPTURE_CYCLES;
    end else begin
      if (ir_capture != 2'h0) begin
        ir_capture <= ir_capture - 2'h1;
      end
      if (wr_req && wb_adr_i == `OFS_MODEM_CTRL) begin
        modem_line_control <= {wdat[7:4], 1'b0, wdat[2:0]};
      end else if (ir_capture == 2'h1) begin
        modem_line_control[`MODEM_IR_EN] <= ir_sync[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cts_sync <= 2'h3;
      dsr_sync <= 2'h3;
      ir_sync <= 2'h0;
    end else begin
      cts_sync <= {cts_sync[0], cts_n_i};
      dsr_sync <= {dsr_sync[0], dsr_n_i};
      ir_sync <= {ir_sync[0], infrared_select_pin_i};
    end
  end

  // ----------------------------------------------------------------
  // fifo level counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_cnt <= '0;
    end else if (rx_flush_o) begin
      rx_cnt <= '0;
    end else if (rx_push_i && !rx_pop_i && rx_cnt < CNT_W'(DEPTH)) begin
      rx_cnt <= rx_cnt + CNT_W'(1);
    end else if (rx_pop_i && !rx_push_i && rx_cnt != '0) begin
      rx_cnt <= rx_cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_cnt <= '0;
    end else if (tx_flush_o) begin
      tx_cnt <= '0;
    end else if (tx_push_i && !tx_pop_i && tx_cnt < CNT_W'(DEPTH)) begin
      tx_cnt <= tx_cnt + CNT_W'(1);
    end else if (tx_pop_i && !tx_push_i && tx_cnt != '0) begin
      tx_cnt <= tx_cnt - CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // trigger requests
  // ----------------------------------------------------------------
  // remembers whether the last reload went above the trigger
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_filled_over <= 1'b0;
    end else if (8'(tx_cnt) > tx_trig) begin
      tx_filled_over <= 1'b1;
    end else if (tx_cnt == '0) begin
      tx_filled_over <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_irq_o <= 1'b0;
      tx_irq_o <= 1'b0;
    end else begin
      rx_irq_o <= fifo_en && 8'(rx_cnt) >= rx_trig;
      tx_irq_o <= fifo_en && (tx_filled_over ? 8'(tx_cnt) < tx_trig : tx_cnt == '0);
    end
  end

  // ----------------------------------------------------------------
  // line and modem outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      char_bits_o <= 4'h5;
      stop_half_o <= 1'b0;
      stop_two_o <= 1'b0;
      parity_en_o <= 1'b0;
      parity_even_o <= 1'b0;
      parity_forced_o <= 1'b0;
      parity_value_o <= 1'b0;
      divisor_sel_o <= 1'b0;
      tx_pin_o <= 1'b1;
    end else begin
      char_bits_o <= 4'h5 + {2'h0, line_format_control[1:0]};
      stop_half_o <= line_format_control[`FMT_STOP] && line_format_control[1:0] == 2'h0;
      stop_two_o <= line_format_control[`FMT_STOP] && line_format_control[1:0] != 2'h0;
      parity_en_o <= line_format_control[`FMT_PAR_EN];
      parity_even_o <= line_format_control[`FMT_PAR_TYPE];
      parity_forced_o <= line_format_control[`FMT_PAR_EN] && line_format_control[`FMT_PAR_FORCE];
      parity_value_o <= !line_format_control[`FMT_PAR_TYPE];
      divisor_sel_o <= line_format_control[`FMT_DIV_SEL];
      if (line_format_control[`FMT_BREAK]) begin
        tx_pin_o <= 1'b0;
      end else if (modem_line_control[`MODEM_IR_EN]) begin
        tx_pin_o <= tx_ir_i;
      end else begin
        tx_pin_o <= tx_serial_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dtr_n_o <= 1'b1;
      rts_n_o <= 1'b1;
      tx_hold_o <= 1'b0;
      loopback_o <= 1'b0;
      xon_any_o <= 1'b0;
      ir_enable_o <= 1'b0;
      prescale_div4_o <= 1'b0;
    end else begin
      // the selected pin of the pair carries receive flow control
      if (enhanced_feature_control[`ENH_AUTO_RTS] && modem_line_control[`MODEM_PAIR_SEL]) begin
        dtr_n_o <= rx_flow_stop_i;
      end else begin
        dtr_n_o <= !modem_line_control[`MODEM_DTR];
      end
      if (enhanced_feature_control[`ENH_AUTO_RTS] && !modem_line_control[`MODEM_PAIR_SEL]) begin
        rts_n_o <= rx_flow_stop_i;
      end else begin
        rts_n_o <= !modem_line_control[`MODEM_RTS];
      end
      tx_hold_o <= enhanced_feature_control[`ENH_AUTO_CTS] &&
        (modem_line_control[`MODEM_PAIR_SEL] ? dsr_sync[1] : cts_sync[1]);
      loopback_o <= modem_line_control[`MODEM_LOOP];
      xon_any_o <= modem_line_control[`MODEM_XON_ANY];
      ir_enable_o <= modem_line_control[`MODEM_IR_EN];
      prescale_div4_o <= modem_line_control[`MODEM_PRESCALE];
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (rd_req) begin
        case (wb_adr_i)
          `OFS_IRQ_SOURCE: wb_dat_o <= {24'h0, {2{fifo_en}},
            (rx_irq_o ? 6'h04 : tx_irq_o ? 6'h02 : 6'h01)};
          `OFS_LINE_FMT: wb_dat_o <= {24'h0, line_format_control};
          `OFS_MODEM_CTRL: wb_dat_o <= {24'h0, modem_line_control};
          `OFS_FEATURE: wb_dat_o <= {24'h0, feature_control};
          `OFS_RX_TRIG: wb_dat_o <= {24'h0, receive_trigger_value};
          `OFS_TX_TRIG: wb_dat_o <= {24'h0, transmit_trigger_value};
          `OFS_ENH_FEATURE: wb_dat_o <= {24'h0, enhanced_feature_control};
          `OFS_LEVELS: wb_dat_o <= {16'h0, 8'(tx_cnt), 8'(rx_cnt)};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  fifo_status_a: assert property (
    rd_req && wb_adr_i == `OFS_IRQ_SOURCE |=> wb_ack_o && wb_dat_o[7:6] == {2{$past(fifo_en)}})
    else $error("fifo status bits do not mirror enable");
  fifo_gate_a: assert property (
    fifo_ctl_write && !wdat[0] |=> !fifo_en && $stable(fifo_ctrl) && !rx_flush_o && !tx_flush_o)
    else $error("fifo control applied without enable bit");
  rx_flush_a: assert property (
    fifo_ctl_write && wdat[0] && wdat[1] |=> rx_flush_o ##1 (rx_cnt == '0 && !rx_flush_o))
    else $error("receive flush did not clear and self clear");
  tx_flush_a: assert property (
    fifo_ctl_write && wdat[0] && wdat[2] |=> tx_flush_o ##1 (tx_cnt == '0 && !tx_flush_o))
    else $error("transmit flush did not clear and self clear");
  tx_request_a: assert property (
    fifo_en && tx_filled_over && 8'(tx_cnt) < tx_trig |=> tx_irq_o)
    else $error("transmit request missing below trigger");
  rx_request_a: assert property (
    fifo_en && 8'(rx_cnt) >= rx_trig |=> rx_irq_o)
    else $error("receive request missing at trigger");
  rx_clear_a: assert property (
    8'(rx_cnt) < rx_trig |=> !rx_irq_o)
    else $error("receive request held below trigger");
  table_a_tx_a: assert property (
    table_sel == table_a |-> tx_trig == 8'h01)
    else $error("table a transmit trigger not one");
  break_hold_a: assert property (
    line_format_control[`FMT_BREAK] [*2] |-> !tx_pin_o)
    else $error("break did not hold transmit low");
  rts_pin_a: assert property (
    !enhanced_feature_control[`ENH_AUTO_RTS] |=> rts_n_o == !$past(modem_line_control[`MODEM_RTS]))
    else $error("rts pin not inverted control bit");
  prescale_a: assert property (
    modem_line_control[`MODEM_PRESCALE] |=> prescale_div4_o)
    else $error("prescaler select not reflected");

endmodule

// >>> bench/line_partner.sv
// remote serial device model: drives the modem handshake inputs after a chosen lag
`timescale 1ns/1ps
module line_partner (
  input wire logic clk_i,
  input wire logic [1:0] busy_i,
  input wire logic [3:0] lag_i,
  output logic cts_n_o,
  output logic dsr_n_o
);
  logic [1:0] shown;
  logic [3:0] wait_cnt;

  initial begin
    shown = 2'b00;
    wait_cnt = 4'h0;
  end

  // a slow far end answers lag_i cycles late, a prompt one at once
  always @(posedge clk_i) begin
    if (busy_i == shown) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= lag_i) begin
      shown <= busy_i;
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  assign cts_n_o = shown[0];
  assign dsr_n_o = shown[1];
endmodule

// >>> bench/uart_fifo_line_modem_control_test.sv
// self-checking bench of the channel configuration block
`timescale 1ns/1ps
`include "uart_cfg_defines.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module uart_fifo_line_modem_control_test;
  import uart_cfg_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, char_bits_o, lag;
  logic [31:0] wb_dat_i, wb_dat_o, q, v;
  logic rx_push_i, rx_pop_i, tx_push_i, tx_pop_i, tx_serial_i, tx_ir_i, rx_flow_stop_i;
  logic cts_n_i, dsr_n_i, infrared_select_pin_i, rx_flush_o, tx_flush_o, rx_irq_o, tx_irq_o;
  logic stop_half_o, stop_two_o, parity_en_o, parity_even_o, parity_forced_o, parity_value_o, divisor_sel_o;
  logic tx_pin_o, dtr_n_o, rts_n_o, tx_hold_o, loopback_o, xon_any_o, ir_enable_o, prescale_div4_o;
  logic [1:0] busy;
  logic [7:0] l, m, f;
  logic rx_seen, tx_seen, p, s;
  int errors, cmp_count, seed, r_lvl, t_lvl, n;
  int rx_tab[3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};
  int tx_tab[3][4] = '{'{1, 1, 1, 1}, '{16, 8, 24, 30}, '{8, 16, 32, 56}};
  logic [7:0] rst_tab[10][2] = '{'{`OFS_IRQ_SOURCE, 8'h01}, '{`OFS_FIFO_CTRL, 8'h00}, '{`OFS_LINE_FMT, 8'h00},
    '{`OFS_MODEM_CTRL, 8'h40}, '{`OFS_FEATURE, 8'h00}, '{`OFS_RX_TRIG, 8'h01}, '{`OFS_TX_TRIG, 8'h01},
    '{`OFS_ENH_FEATURE, 8'h00}, '{8'h30, 8'h00}, '{`OFS_LEVELS, 8'h00}};

  uart_fifo_line_modem_control #(.DEPTH(64), .CNT_W(7)) uut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .rx_push_i, .rx_pop_i, .tx_push_i, .tx_pop_i, .tx_serial_i, .tx_ir_i, .rx_flow_stop_i, .cts_n_i, .dsr_n_i,
    .infrared_select_pin_i, .rx_flush_o, .tx_flush_o, .rx_irq_o, .tx_irq_o, .char_bits_o, .stop_half_o,
    .stop_two_o, .parity_en_o, .parity_even_o, .parity_forced_o, .parity_value_o, .divisor_sel_o, .tx_pin_o,
    .dtr_n_o, .rts_n_o, .tx_hold_o, .loopback_o, .xon_any_o, .ir_enable_o, .prescale_div4_o);

  line_partner far (.clk_i(clk_i), .busy_i(busy), .lag_i(lag), .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (rx_flush_o === 1'b1) rx_seen <= 1'b1;
    if (tx_flush_o === 1'b1) tx_seen <= 1'b1;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task close_out;
    $display("counts: compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task tick(input int k);
    repeat (k) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int c;
    c = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'h1;
    @(posedge clk_i);
    // ack and read data are taken at the edge that samples ack high
    while (wb_ack_o !== 1'b1) begin
      c++;
      if (c > 20) begin
        errors++;
        close_out;
      end
      @(posedge clk_i);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // b: 0 rx push, 1 rx pop, 2 tx push, 3 tx pop
  task pulse(input int b, input int k);
    repeat (k) begin
      @(posedge clk_i);
      {tx_pop_i, tx_push_i, rx_pop_i, rx_push_i} <= 4'h1 << b;
      @(posedge clk_i);
      {tx_pop_i, tx_push_i, rx_pop_i, rx_push_i} <= 4'h0;
    end
    tick(3);
  endtask

  function int trig(input int t, input int c, input bit rx, input int prog);
    if (t == 3) return prog;
    return rx ? rx_tab[t][c] : tx_tab[t][c];
  endfunction

  function logic exp_pin(input logic [7:0] lf, input logic [7:0] mc);
    return lf[6] ? 1'b0 : (mc[6] ? tx_ir_i : tx_serial_i);
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 72836;
    errors = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {rx_push_i, rx_pop_i, tx_push_i, tx_pop_i, tx_serial_i, tx_ir_i, rx_flow_stop_i} = '0;
    infrared_select_pin_i = 1'b1;
    busy = 2'b00;
    lag = 4'h0;
    rx_seen = 1'b0;
    tx_seen = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(8);
    `CHK(char_bits_o, 4'h5)
    `CHK({dtr_n_o, rts_n_o}, 2'b11)
    `CHK({ir_enable_o, tx_pin_o}, 2'b10)
    bus(1'b1, 8'h30, 8'hff);
    bus(1'b1, `OFS_IRQ_SOURCE, 8'hff);
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, rst_tab[i][0], 8'h00);
      `CHK(q, {24'h0, rst_tab[i][1]})
    end
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      v = $random(seed);
      l = {v[7:2], i[1:0]};
      m = v[15:8];
      @(posedge clk_i);
      tx_serial_i <= v[16];
      tx_ir_i <= v[17];
      bus(1'b1, `OFS_LINE_FMT, l);
      bus(1'b1, `OFS_MODEM_CTRL, m);
      tick(2);
      `CHK(char_bits_o, 4'h5 + {2'b00, l[1:0]})
      `CHK({stop_two_o, stop_half_o}, {l[2] & (l[1:0] != 2'b00), l[2] & (l[1:0] == 2'b00)})
      `CHK(parity_en_o, l[3])
      if (l[3] & ~l[5]) `CHK(parity_even_o, l[4])
      if (l[3] & l[5]) `CHK({parity_forced_o, parity_value_o}, {1'b1, ~l[4]})
      `CHK(divisor_sel_o, l[7])
      `CHK(tx_pin_o, exp_pin(l, m))
      `CHK({dtr_n_o, rts_n_o}, {~m[0], ~m[1]})
      `CHK({ir_enable_o, xon_any_o, loopback_o}, m[6:4])
      `CHK(prescale_div4_o, m[7])
      bus(1'b0, `OFS_LINE_FMT, 8'h00);
      `CHK(q[7:0], l)
      bus(1'b0, `OFS_MODEM_CTRL, 8'h00);
      `CHK(q[7:0], m & 8'hf7)
    end
    bus(1'b1, `OFS_LINE_FMT, 8'h00);
    bus(1'b1, `OFS_MODEM_CTRL, 8'h00);
    $display("format and modem test done");
    for (int t = 0; t < 4; t++) begin
      for (int c = 0; c < 4; c++) begin
        v = $random(seed);
        bus(1'b1, `OFS_FEATURE, {t[1:0], 6'h0});
        if (t == 3) begin
          bus(1'b1, `OFS_RX_TRIG, {3'h0, v[12:8]} + 8'h01);
          bus(1'b1, `OFS_TX_TRIG, {3'h0, v[20:16]} + 8'h01);
        end
        // bit 3 is the legacy transfer mode bit, drawn at random since it must change nothing
        f = {c[1:0], v[1:0], v[2], 3'h1};
        r_lvl = trig(t, c, 1'b1, int'(v[12:8]) + 1);
        t_lvl = trig(t, int'(v[1:0]), 1'b0, int'(v[20:16]) + 1);
        bus(1'b1, `OFS_FIFO_CTRL, f | 8'h06);
        tick(3);
        `CHK(tx_irq_o, 1'b1)
        bus(1'b0, `OFS_IRQ_SOURCE, 8'h00);
        `CHK(q[7:6], 2'b11)
        pulse(0, r_lvl - 1);
        `CHK(rx_irq_o, 1'b0)
        pulse(0, 1);
        if (t == 0) `CHK(rx_irq_o, 1'b1)
        if (t == 1) `CHK(rx_irq_o, 1'b1)
        if (t == 2) `CHK(rx_irq_o, 1'b1)
        if (t == 3) `CHK(rx_irq_o, 1'b1)
        rx_seen = 1'b0;
        bus(1'b1, `OFS_FIFO_CTRL, f | 8'h02);
        tick(3);
        `CHK({rx_irq_o, rx_seen}, 2'b01)
        pulse(0, r_lvl - 1);
        `CHK(rx_irq_o, 1'b0)
        pulse(0, 1);
        `CHK(rx_irq_o, 1'b1)
        pulse(1, 1);
        `CHK(rx_irq_o, 1'b0)
        pulse(2, t_lvl);
        `CHK(tx_irq_o, 1'b0)
        pulse(2, 1);
        pulse(3, 1);
        `CHK(tx_irq_o, 1'b0)
        pulse(3, 1);
        `CHK(tx_irq_o, 1'b1)
        bus(1'b0, `OFS_LEVELS, 8'h00);
        `CHK(q, {16'h0, 8'(t_lvl - 1), 8'(r_lvl - 1)})
        pulse(2, 2);
        tx_seen = 1'b0;
        bus(1'b1, `OFS_FIFO_CTRL, f | 8'h04);
        tick(3);
        `CHK({tx_irq_o, tx_seen}, 2'b11)
      end
    end
    rx_seen = 1'b0;
    tx_seen = 1'b0;
    bus(1'b1, `OFS_FIFO_CTRL, 8'hce);
    tick(3);
    `CHK({rx_seen, tx_seen, rx_irq_o, tx_irq_o}, 4'h0)
    bus(1'b0, `OFS_IRQ_SOURCE, 8'h00);
    `CHK(q[7:6], 2'b00)
    $display("trigger and flush test done");
    bus(1'b1, `OFS_ENH_FEATURE, 8'hc0);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      p = k[1];
      s = k[0];
      bus(1'b1, `OFS_MODEM_CTRL, {5'h0, p, 2'b00});
      @(posedge clk_i);
      rx_flow_stop_i <= s;
      busy <= p ? {s, ~s} : {~s, s};
      lag <= v[3:0];
      n = 0;
      tick(1);
      while ({dsr_n_i, cts_n_i} !== busy) begin
        n++;
        if (n > 40) begin
          errors++;
          close_out;
        end
        tick(1);
      end
      tick(3);
      `CHK(tx_hold_o, s)
      `CHK(p ? dtr_n_o : rts_n_o, s)
      `CHK(p ? rts_n_o : dtr_n_o, 1'b1)
    end
    bus(1'b1, `OFS_ENH_FEATURE, 8'h00);
    $display("flow control test done");
    close_out;
  end
endmodule
